// *** verilog/ebtc_pkg.sv ***
package ebtc_pkg;
    localparam int          TIMER_COUNT   = 2;
    localparam int          COUNT_WIDTH   = 8;
    localparam int          PRESC_WIDTH   = 7;
    localparam logic [7:0]  COUNT_ZERO    = 8'h00;
    localparam logic [7:0]  COUNT_TOP     = 8'hFF;
    localparam logic [7:0]  COUNT_STEP    = 8'h01;
    localparam logic [6:0]  PRESC_ZERO    = 7'h00;
    localparam logic [6:0]  PRESC_ONE     = 7'h01;
    localparam logic [2:0]  TICK_ZERO     = 3'h0;
    localparam logic [2:0]  TICK_ONE      = 3'h1;
    localparam int          CTRL_DIV_HI   = 7;
    localparam int          CTRL_DIV_LO   = 5;
    localparam int          CTRL_RUN_BIT  = 4;
    localparam int          CTRL_CLR_BIT  = 3;
    localparam logic [2:0]  DIV_RESET     = 3'h0;
    typedef enum logic [3:0] {
        MODE_FREE   = 4'h1,
        MODE_DOWN   = 4'h2,
        MODE_MODULO = 4'h4,
        MODE_UPDOWN = 4'h8
    } ebtc_mode_e;
    typedef enum logic [1:0] {
        DIR_UP   = 2'h1,
        DIR_DOWN = 2'h2
    } ebtc_dir_e;
endpackage : ebtc_pkg

// *** verilog/ebtc_timer.sv ***
`timescale 1ns/1ps
`default_nettype none
module ebtc_timer
    import ebtc_pkg::*;
(
    input  wire logic                   sys_clk,
    input  wire logic                   rst,
    input  wire logic                   clkEn,
    input  wire logic                   tickPulse,
    input  wire logic [2:0]             prescaleSelect,
    input  wire logic                   runControlBit,
    input  wire logic                   counterClearBit,
    input  wire logic [3:0]             modeSelect,
    input  wire logic [7:0]             channelZeroCompareValue,
    output logic [7:0]                  countValue,
    output logic                        terminalEvent
);
    logic [6:0]  prescReg;
    logic [6:0]  prescNext;
    logic [7:0]  countReg;
    logic [7:0]  countNext;
    ebtc_dir_e   dirReg;
    ebtc_dir_e   dirNext;
    logic        stepEn;
    logic        eventNext;
    logic        eventReg;
    logic [6:0]  prescMask;

    assign countValue    = countReg;
    assign terminalEvent = eventReg;

    ////////////////////////////////////////////////////////////////////////////
    always_comb begin
        prescMask = 7'((8'h01 << prescaleSelect) - 8'h01);
        prescNext = prescReg;
        countNext = countReg;
        dirNext   = dirReg;
        eventNext = 1'b0;
        stepEn    = 1'b0;
        if (runControlBit && tickPulse) begin
            prescNext = 7'((prescReg + PRESC_ONE) & prescMask);
            stepEn    = ((prescReg & prescMask) == prescMask);
        end
        if (stepEn) begin
            case (modeSelect)
                MODE_FREE: begin
                    countNext = countReg + COUNT_STEP;
                    eventNext = (countNext == COUNT_TOP);
                end
                MODE_MODULO: begin
                    countNext = (countReg == channelZeroCompareValue) ? COUNT_ZERO : countReg + COUNT_STEP;
                    eventNext = (countNext == channelZeroCompareValue);
                end
                MODE_DOWN: begin
                    countNext = (countReg == COUNT_ZERO) ? COUNT_ZERO : countReg - COUNT_STEP;
                    eventNext = (countReg != COUNT_ZERO) && (countNext == COUNT_ZERO);
                end
                MODE_UPDOWN: begin
                    if (dirReg == DIR_UP) begin
                        if (countReg >= channelZeroCompareValue) begin
                            dirNext   = DIR_DOWN;
                            countNext = countReg - COUNT_STEP;
                        end else begin
                            countNext = countReg + COUNT_STEP;
                        end
                    end else begin
                        if (countReg == COUNT_ZERO) begin
                            dirNext   = DIR_UP;
                            countNext = COUNT_STEP;
                        end else begin
                            countNext = countReg - COUNT_STEP;
                        end
                    end
                    eventNext = (countNext == COUNT_ZERO);
                end
                default: begin
                    countNext = countReg;
                end
            endcase
        end
        if (counterClearBit) begin
            // A step cut short by a clear must not raise a terminal event.
            countNext = COUNT_ZERO;
            prescNext = PRESC_ZERO;
            dirNext   = DIR_UP;
            eventNext = 1'b0;
        end
    end

    always_ff @(posedge sys_clk) begin
        if (rst) begin
            prescReg <= PRESC_ZERO;
            countReg <= COUNT_ZERO;
            dirReg   <= DIR_UP;
            eventReg <= 1'b0;
        end else if (clkEn) begin
            prescReg <= prescNext;
            countReg <= countNext;
            dirReg   <= dirNext;
            eventReg <= eventNext;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // stopped counter holds
    a_hold_stopped: assert property (@(posedge sys_clk) disable iff (rst)
        (clkEn && !runControlBit && !counterClearBit) |=> $stable(countReg))
        else $error("Counter moved while stopped.");
    a_clear_zero: assert property (@(posedge sys_clk) disable iff (rst)
        (clkEn && counterClearBit) |=> (countReg == COUNT_ZERO))
        else $error("Clear did not zero counter.");
    a_free_wrap: assert property (@(posedge sys_clk) disable iff (rst)
        (clkEn && stepEn && !counterClearBit && modeSelect == MODE_FREE && countReg == COUNT_TOP)
        |=> (countReg == COUNT_ZERO))
        else $error("Free mode did not wrap.");
    a_free_flag: assert property (@(posedge sys_clk) disable iff (rst)
        (eventReg && modeSelect == MODE_FREE && $past(modeSelect) == MODE_FREE && !$past(counterClearBit))
        |-> (countReg == COUNT_TOP))
        else $error("Free flag off top.");
    a_mod_wrap: assert property (@(posedge sys_clk) disable iff (rst)
        (clkEn && stepEn && !counterClearBit && modeSelect == MODE_MODULO
         && countReg == channelZeroCompareValue) |=> (countReg == COUNT_ZERO))
        else $error("Modulo did not wrap.");
    a_step_one: assert property (@(posedge sys_clk) disable iff (rst)
        (clkEn && stepEn && !counterClearBit && modeSelect == MODE_FREE)
        |=> (countReg == $past(countReg) + COUNT_STEP))
        else $error("Count did not step by one.");
    a_div_two: assert property (@(posedge sys_clk) disable iff (rst)
        (clkEn && stepEn && prescaleSelect == 3'h1) ##1 (prescaleSelect == 3'h1) |-> !stepEn)
        else $error("Prescaler two stepped twice.");
    a_run_gate: assert property (@(posedge sys_clk) disable iff (rst)
        (clkEn && runControlBit && tickPulse && prescaleSelect == 3'h0 && modeSelect == MODE_FREE
         && !counterClearBit) |=> (countReg == $past(countReg) + COUNT_STEP))
        else $error("Running counter did not step.");
    c_free_wrap: cover property (@(posedge sys_clk) disable iff (rst)
        modeSelect == MODE_FREE && countReg == COUNT_TOP ##1 countReg == COUNT_ZERO);
    c_mod_event: cover property (@(posedge sys_clk) disable iff (rst)
        modeSelect == MODE_MODULO && eventReg);
    c_updown_turn: cover property (@(posedge sys_clk) disable iff (rst)
        dirReg == DIR_DOWN ##1 dirReg == DIR_UP);
endmodule // ebtc_timer
`default_nettype wire

// *** verilog/ebtc_top.sv ***
`timescale 1ns/1ps
`default_nettype none
module ebtc_top
    import ebtc_pkg::*;
(
    input  wire logic                   sys_clk,
    input  wire logic                   rst,
    input  wire logic                   clkEn,
    input  wire logic [2:0]             tickRateSelect,
    input  wire logic [15:0]            timerControlReg,
    input  wire logic [7:0]             modeSelect,
    input  wire logic [15:0]            channelZeroCompareValue,
    input  wire logic [15:0]            channelOneCompareValue,
    input  wire logic [1:0]             terminalCountIrqMask,
    input  wire logic [1:0]             timerIrqEnable,
    input  wire logic [1:0]             flagClear,
    output logic [15:0]                 countValueReg,
    output logic [1:0]                  terminalCountFlag,
    output logic [1:0]                  cpuTimerIrqFlag,
    output logic [1:0]                  timerIrqReq,
    output logic [3:0]                  comparePin
);
    // Control byte per timer: [7:5] prescale_select, [4] run, [3] clear.
    logic [2:0]  tickCntReg;
    logic [2:0]  tickCntNext;
    logic        tickReg;
    logic        tickNext;
    logic [2:0]  tickLimit;
    logic [15:0] countWire;
    logic [1:0]  eventWire;
    logic [15:0] countValueNext;
    logic [1:0]  flagReg;
    logic [1:0]  flagNext;
    logic [1:0]  cpuReg;
    logic [1:0]  cpuNext;
    logic [1:0]  irqReg;
    logic [1:0]  irqNext;
    logic [3:0]  pinReg;
    logic [3:0]  pinNext;

    assign terminalCountFlag = flagReg;
    assign cpuTimerIrqFlag   = cpuReg;
    assign timerIrqReq       = irqReg;
    assign comparePin        = pinReg;

    ////////////////////////////////////////////////////////////////////////////
    // tick from system clock
    always_comb begin
        tickLimit   = 3'((4'h1 << tickRateSelect[1:0]) - 4'h1);
        tickCntNext = tickCntReg + TICK_ONE;
        tickNext    = 1'b0;
        if (tickCntReg >= tickLimit) begin
            tickCntNext = TICK_ZERO;
            tickNext    = 1'b1;
        end
    end

    always_ff @(posedge sys_clk) begin
        if (rst) begin
            tickCntReg <= TICK_ZERO;
            tickReg    <= 1'b0;
        end else if (clkEn) begin
            tickCntReg <= tickCntNext;
            tickReg    <= tickNext;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    for (genvar t = 0; t < TIMER_COUNT; t++) begin : gTimer
        ebtc_timer uTimer (
            .sys_clk                 (sys_clk),
            .rst                     (rst),
            .clkEn                   (clkEn),
            .tickPulse               (tickReg),
            .prescaleSelect          (timerControlReg[8*t+CTRL_DIV_LO +: 3]),
            .runControlBit           (timerControlReg[8*t+CTRL_RUN_BIT]),
            .counterClearBit         (timerControlReg[8*t+CTRL_CLR_BIT]),
            .modeSelect              (modeSelect[4*t +: 4]),
            .channelZeroCompareValue (channelZeroCompareValue[8*t +: 8]),
            .countValue              (countWire[8*t +: 8]),
            .terminalEvent           (eventWire[t])
        );
    end

    ////////////////////////////////////////////////////////////////////////////
    always_comb begin
        countValueNext = countWire;
        flagNext       = flagReg;
        cpuNext        = cpuReg;
        irqNext        = irqReg;
        pinNext        = pinReg;
        for (int t = 0; t < TIMER_COUNT; t++) begin
            // Set wins over a clear in the same cycle.
            if (flagClear[t]) begin
                flagNext[t] = 1'b0;
                cpuNext[t]  = 1'b0;
            end
            if (eventWire[t]) begin
                flagNext[t] = 1'b1;
                if (terminalCountIrqMask[t]) begin
                    cpuNext[t] = 1'b1;
                end
            end
            irqNext[t] = cpuNext[t] && terminalCountIrqMask[t] && timerIrqEnable[t];
            pinNext[2*t]   = (countWire[8*t +: 8] == channelZeroCompareValue[8*t +: 8]);
            pinNext[2*t+1] = (countWire[8*t +: 8] == channelOneCompareValue[8*t +: 8]);
        end
    end

    always_ff @(posedge sys_clk) begin
        if (rst) begin
            countValueReg <= 16'h0000;
            flagReg       <= 2'h0;
            cpuReg        <= 2'h0;
            irqReg        <= 2'h0;
            pinReg        <= 4'h0;
        end else if (clkEn) begin
            countValueReg <= countValueNext;
            flagReg       <= flagNext;
            cpuReg        <= cpuNext;
            irqReg        <= irqNext;
            pinReg        <= pinNext;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // request needs both
    a_irq_gate: assert property (@(posedge sys_clk) disable iff (rst)
        irqReg[0] |-> (cpuReg[0] && $past(terminalCountIrqMask[0]) && $past(timerIrqEnable[0])))
        else $error("Request without mask and enable.");
    a_cpu_mask: assert property (@(posedge sys_clk) disable iff (rst)
        ($rose(cpuReg[0]) && $past(clkEn)) |-> $past(terminalCountIrqMask[0]) && $past(eventWire[0]))
        else $error("CPU flag set while masked.");
    a_flag_set: assert property (@(posedge sys_clk) disable iff (rst)
        (clkEn && eventWire[1]) |=> flagReg[1])
        else $error("Terminal flag not set.");
    a_read_count: assert property (@(posedge sys_clk) disable iff (rst)
        clkEn |=> (countValueReg == $past(countWire)))
        else $error("Count readback stale.");
    a_irq_raise: assert property (@(posedge sys_clk) disable iff (rst)
        (clkEn && cpuReg[1] && terminalCountIrqMask[1] && timerIrqEnable[1] && !flagClear[1]) |=> irqReg[1])
        else $error("Request missing with mask and enable.");
    a_freeze_hold: assert property (@(posedge sys_clk) disable iff (rst)
        !clkEn |=> ($stable(countValueReg) && $stable(flagReg) && $stable(irqReg)))
        else $error("State moved with clock enable low.");
    c_irq: cover property (@(posedge sys_clk) disable iff (rst) irqReg[1]);
endmodule // ebtc_top
`default_nettype wire

// *** test/ebtc_bench.sv ***
`timescale 1ns/1ps
`default_nettype none
module ebtc_bench
    import ebtc_pkg::*;
;
    logic        sys_clk    = 1'b0;
    logic        rst        = 1'b1;
    logic        clkEn      = 1'b1;
    logic [2:0]  tickRate   = 3'h0;
    logic [15:0] ctrl       = 16'h0000;
    logic [7:0]  mode       = {MODE_MODULO, MODE_FREE};
    logic [15:0] cc0        = 16'h0000;
    logic [15:0] cc1        = 16'h0000;
    logic [1:0]  irqMask    = 2'h0;
    logic [1:0]  irqEn      = 2'h0;
    logic [1:0]  flagClr    = 2'h0;
    logic [15:0] countValueReg;
    logic [1:0]  termFlag;
    logic [1:0]  cpuFlag;
    logic [1:0]  irqReq;
    logic [3:0]  pins;
    int          badCount   = 0;
    int          cmpCount   = 0;
    int          cycles     = 0;

    ebtc_top u_dut (
        .sys_clk                 (sys_clk),
        .rst                     (rst),
        .clkEn                   (clkEn),
        .tickRateSelect          (tickRate),
        .timerControlReg         (ctrl),
        .modeSelect              (mode),
        .channelZeroCompareValue (cc0),
        .channelOneCompareValue  (cc1),
        .terminalCountIrqMask    (irqMask),
        .timerIrqEnable          (irqEn),
        .flagClear               (flagClr),
        .countValueReg           (countValueReg),
        .terminalCountFlag       (termFlag),
        .cpuTimerIrqFlag         (cpuFlag),
        .timerIrqReq             (irqReq),
        .comparePin              (pins)
    );

    always #10 sys_clk = ~sys_clk;

    // A hang is cut short well beyond the expected run of about 2000 cycles.
    always @(posedge sys_clk) begin
        cycles <= cycles + 1;
        if (cycles == 20000) begin
            badCount++;
            results();
        end
    end

    ////////////////////////////////////////////////////////////////////////
    task automatic results();
        $display("compares %0d mismatches %0d", cmpCount, badCount);
        if (badCount == 0 && cmpCount > 0) $display("Test passed");
        else $display("Test failed");
        $finish;
    endtask

    task automatic chk(input logic [15:0] got, input logic [15:0] exp);
        cmpCount++;
        if (got !== exp) begin
            badCount++;
            $display("unexpected at %0t: got %h expected %h", $time, got, exp);
        end
    endtask

    task automatic tick(input int n);
        repeat (n) @(posedge sys_clk);
        #1;
    endtask

    function automatic logic [7:0] cnt(input int t);
        return countValueReg[8*t +: 8];
    endfunction

    task automatic setCtl(input int t, input logic [2:0] div, input logic run, input logic clr);
        @(posedge sys_clk);
        ctrl[8*t +: 8] <= {div, run, clr, 3'h0};
    endtask

    // Measures cycles between two count changes and checks the step is one.
    task automatic period(input int t, output int p);
        logic [7:0] v;
        int         i;
        v = cnt(t);
        for (i = 0; i < 400 && cnt(t) === v; i++) tick(1);
        v = cnt(t);
        for (p = 0; p < 400 && cnt(t) === v; p++) tick(1);
        chk({8'h00, cnt(t)}, {8'h00, v + 8'h01});
    endtask

    task automatic waitCnt(input int t, input logic [7:0] v);
        int i;
        for (i = 0; i < 600 && cnt(t) !== v; i++) tick(1);
        chk({8'h00, cnt(t)}, {8'h00, v});
    endtask

    ////////////////////////////////////////////////////////////////////////
    task automatic testPrescale();
        int t;
        int d;
        int p;
        // Timer one runs in modulo mode; a full-range compare lets it count freely here.
        @(posedge sys_clk);
        cc0[15:8] <= 8'hFF;
        for (t = 0; t < 2; t++) begin
            for (d = 0; d < 8; d++) begin
                setCtl(t, d[2:0], 1'b1, 1'b0);
                tick(2);
                period(t, p);
                chk(p[15:0], 16'h0001 << d);
            end
            setCtl(t, 3'h0, 1'b0, 1'b1);
        end
        for (d = 0; d < 4; d++) begin
            @(posedge sys_clk);
            tickRate <= d[2:0];
            setCtl(0, 3'h1, 1'b1, 1'b0);
            tick(4);
            period(0, p);
            chk(p[15:0], 16'h0002 << d);
        end
        @(posedge sys_clk);
        tickRate <= 3'h0;
    endtask

    task automatic testHaltClear();
        logic [7:0] v;
        setCtl(0, 3'h0, 1'b1, 1'b0);
        tick(5);
        setCtl(0, 3'h0, 1'b0, 1'b0);
        tick(4);
        v = cnt(0);
        tick(20);
        chk({8'h00, cnt(0)}, {8'h00, v});
        setCtl(0, 3'h0, 1'b1, 1'b0);
        tick(5);
        chk({15'h0, cnt(0) === v}, 16'h0000);
        setCtl(0, 3'h0, 1'b1, 1'b1);
        tick(5);
        chk({8'h00, cnt(0)}, 16'h0000);
        tick(10);
        chk({8'h00, cnt(0)}, 16'h0000);
    endtask

    task automatic testFreeWrap();
        int i;
        int n0;
        int n1;
        @(posedge sys_clk);
        cc0[7:0] <= 8'h10;
        cc1[7:0] <= 8'h20;
        irqMask  <= 2'h1;
        irqEn    <= 2'h1;
        flagClr  <= 2'h1;
        repeat (2) @(posedge sys_clk);
        flagClr  <= 2'h0;
        setCtl(0, 3'h0, 1'b1, 1'b0);
        waitCnt(0, 8'hFE);
        chk({14'h0, termFlag}, 16'h0000);
        tick(1);
        chk({8'h00, cnt(0)}, 16'h00FF);
        tick(1);
        chk({8'h00, cnt(0)}, 16'h0000);
        tick(3);
        chk({14'h0, termFlag}, 16'h0001);
        chk({14'h0, cpuFlag}, 16'h0001);
        chk({14'h0, irqReq}, 16'h0001);
        n0 = 0;
        n1 = 0;
        for (i = 0; i < 256; i++) begin
            tick(1);
            n0 += int'(pins[0] === 1'b1);
            n1 += int'(pins[1] === 1'b1);
        end
        chk(n0[15:0], 16'h0001);
        chk(n1[15:0], 16'h0001);
        setCtl(0, 3'h0, 1'b0, 1'b1);
    endtask

    task automatic testModuloIrq();
        int         c;
        int         i;
        logic [7:0] top;
        @(posedge sys_clk);
        cc0[15:8] <= 8'h05;
        for (c = 0; c < 4; c++) begin
            setCtl(1, 3'h0, 1'b0, 1'b1);
            irqMask[1] <= c[0];
            irqEn[1]   <= c[1];
            flagClr    <= 2'h2;
            repeat (3) @(posedge sys_clk);
            flagClr    <= 2'h0;
            setCtl(1, 3'h0, 1'b1, 1'b0);
            top = 8'h00;
            for (i = 0; i < 40; i++) begin
                tick(1);
                if (cnt(1) > top) top = cnt(1);
            end
            chk({8'h00, top}, 16'h0005);
            chk({15'h0, termFlag[1]}, 16'h0001);
            chk({15'h0, cpuFlag[1]}, {15'h0, c[0]});
            chk({15'h0, irqReq[1]}, {15'h0, c[0] & c[1]});
        end
    endtask

    task automatic testFreeze();
        logic [15:0] v;
        setCtl(0, 3'h0, 1'b1, 1'b0);
        tick(5);
        @(posedge sys_clk);
        clkEn <= 1'b0;
        tick(2);
        v = countValueReg;
        tick(10);
        chk(countValueReg, v);
        @(posedge sys_clk);
        clkEn <= 1'b1;
        tick(3);
        chk({15'h0, countValueReg === v}, 16'h0000);
        setCtl(0, 3'h0, 1'b0, 1'b1);
    endtask

    ////////////////////////////////////////////////////////////////////////
    initial begin
        repeat (6) @(posedge sys_clk);
        rst <= 1'b0;
        tick(1);
        chk(countValueReg, 16'h0000);
        chk({10'h0, termFlag, cpuFlag, irqReq}, 16'h0000);
        testPrescale();
        testHaltClear();
        testFreeWrap();
        testModuloIrq();
        testFreeze();
        results();
    end
endmodule // ebtc_bench
`default_nettype wire
